// ### include/mrpt_regs.svh
// constants of the message translator: opcodes, codes and limits
`ifndef MRPT_REGS_SVH
`define MRPT_REGS_SVH
`define MRPT_NAT_PRD     8'h20
`define MRPT_NAT_NPRD    8'h00
`define MRPT_NAT_NPRRA   8'h04
`define MRPT_NAT_PWR     8'h1e
`define MRPT_NAT_NPWR    8'h02
`define MRPT_NAT_PPRINT  8'h22
`define MRPT_FC_RCOIL    8'h01
`define MRPT_FC_RINST    8'h02
`define MRPT_FC_RHOLD    8'h03
`define MRPT_FC_RINREG   8'h04
`define MRPT_FC_WCOIL    8'h05
`define MRPT_FC_WREG     8'h06
`define MRPT_FC_WCOILS   8'h0f
`define MRPT_FC_WREGS    8'h10
`define MRPT_FC_ENCAP    8'h11
`define MRPT_PRM_QUERY   8'h01
`define MRPT_PRM_REPLY   8'h02
`define MRPT_CLS_COIL    3'h0
`define MRPT_CLS_INBIT   3'h1
`define MRPT_CLS_INREG   3'h3
`define MRPT_CLS_HOLD    3'h4
`define MRPT_COIL_LIMIT  16'h0800
`define MRPT_COIL_ON     16'hff00
`endif

// ### include/mrpt_pkg.sv
// types shared by the message translator modules
package mrpt_pkg;
	typedef enum logic [1:0] {
		MRPT_MODE_NATIVE,
		MRPT_MODE_GATEWAY,
		MRPT_MODE_MASTER,
		MRPT_NETWORK_BRIDGING_MODE
	} mrpt_mode_e;
	typedef enum logic [1:0] {
		MRPT_K_XLATE,
		MRPT_K_ENCAP,
		MRPT_K_ERROR,
		MRPT_K_FWD
	} mrpt_kind_e;
	typedef struct packed {
		mrpt_kind_e  kind;
		logic        to_mb;
		logic [7:0]  opcode;
		logic [7:0]  param;
		logic [7:0]  inner;
		logic [15:0] addr;
		logic [15:0] count;
		logic [15:0] mask;
		logic [15:0] data;
	} mrpt_msg_s;
endpackage : mrpt_pkg

// ### include/mrpt_msg_if.sv
// valid/ready carrier of one message word between translator modules
`timescale 1ns/100ps
`default_nettype none
interface mrpt_msg_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : mrpt_msg_if
`default_nettype wire

// ### logic/mrpt_skid.sv
// two-entry message buffer with honest full and empty
`timescale 1ns/100ps
`default_nettype none
module mrpt_skid #(
	parameter int W = 8
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	mrpt_msg_if.snk   in_if,
	mrpt_msg_if.src   out_if
);
	logic [W-1:0] mem_q [2];
	logic         wp_q;
	logic         rp_q;
	logic [1:0]   cnt_q;
	logic         push;
	logic         pop;

	if (W < 1) begin : g_chk
		$error("mrpt_skid: width must be at least one");
	end

	assign in_if.ready  = (cnt_q != 2'h2);
	assign out_if.valid = (cnt_q != 2'h0);
	assign out_if.data  = mem_q[rp_q];
	assign push         = in_if.valid & in_if.ready;
	assign pop          = out_if.valid & out_if.ready;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wp_q] <= in_if.data;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			wp_q  <= wp_q ^ push;
			rp_q  <= rp_q ^ pop;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	AST_SKID_BOUND: assert property (@(posedge clk_i) disable iff (!rstn_i)
		cnt_q <= 2'h2) else $error("buffer count out of range");
endmodule : mrpt_skid
`default_nettype wire

// ### logic/mrpt_mbdec.sv
// decode of a serial-bus reference: class, function code, register, bit
`timescale 1ns/100ps
`default_nettype none
`include "mrpt_regs.svh"
module mrpt_mbdec (
	input  wire logic [7:0]  fc_i,
	input  wire logic [2:0]  class_i,
	input  wire logic [15:0] index_i,
	output logic             legal_o,
	output logic             is_bit_o,
	output logic [15:0]      reg_o,
	output logic [3:0]       bit_o
);
	logic [15:0] zidx;

	assign zidx = index_i - 16'h0001;

	always_comb begin
		legal_o  = 1'b0;
		is_bit_o = 1'b0;
		unique case (class_i)
			`MRPT_CLS_COIL: begin
				is_bit_o = 1'b1;
				legal_o  = fc_i == `MRPT_FC_RCOIL || fc_i == `MRPT_FC_WCOIL
					|| fc_i == `MRPT_FC_WCOILS;
			end
			`MRPT_CLS_INBIT: begin
				is_bit_o = 1'b1;
				legal_o  = fc_i == `MRPT_FC_RINST;
			end
			`MRPT_CLS_INREG: legal_o = fc_i == `MRPT_FC_RINREG;
			`MRPT_CLS_HOLD: begin
				legal_o = fc_i == `MRPT_FC_RHOLD || fc_i == `MRPT_FC_WREG
					|| fc_i == `MRPT_FC_WREGS;
			end
			default: legal_o = 1'b0;
		endcase
		if (index_i == 16'h0000) begin
			legal_o = 1'b0;
		end
	end

	// items count from one; sixteen bits share one native register
	assign reg_o = is_bit_o ? ({4'h0, zidx[15:4]} + 16'h0001) : index_i;
	assign bit_o = is_bit_o ? zidx[3:0] : 4'h0;
endmodule : mrpt_mbdec
`default_nettype wire

// ### logic/mrpt_xlate.sv
// message translator between the native register protocol and the serial bus
`timescale 1ns/100ps
`default_nettype none
`include "mrpt_regs.svh"
module mrpt_xlate (
	input  wire logic                   clk_i,
	input  wire logic                   rstn_i,
	input  wire mrpt_pkg::mrpt_mode_e   mode_i,
	input  wire logic [7:0]             cfg_opcode_i,
	input  wire logic [15:0]            cfg_bias_i,
	input  wire logic                   req_valid_i,
	output logic                        req_ready_o,
	input  wire logic                   req_from_mb_i,
	input  wire logic                   req_encap_i,
	input  wire logic [7:0]             req_opcode_i,
	input  wire logic                   req_has_param_i,
	input  wire logic [7:0]             req_param_i,
	input  wire logic [2:0]             req_class_i,
	input  wire logic [15:0]            req_addr_i,
	input  wire logic [15:0]            req_count_i,
	input  wire logic [15:0]            req_mask_i,
	input  wire logic [15:0]            req_data_i,
	output logic                        rsp_valid_o,
	input  wire logic                   rsp_ready_i,
	output mrpt_pkg::mrpt_msg_s         rsp_msg_o
);
	localparam int W = $bits(mrpt_pkg::mrpt_msg_s);

	typedef enum logic {MRPT_ST_IDLE, MRPT_ST_PUSH} mrpt_st_e;

	mrpt_st_e            st_q;
	mrpt_pkg::mrpt_msg_s msg_q;
	mrpt_pkg::mrpt_msg_s msg_d;
	mrpt_pkg::mrpt_msg_s to_mb;
	mrpt_pkg::mrpt_msg_s to_nat;
	mrpt_pkg::mrpt_msg_s err;
	logic                acc;
	logic                legal;
	logic                is_bit;
	logic [15:0]         dreg;
	logic [3:0]          dbit;
	logic                mb_encap;
	logic                mb_reply;
	logic [15:0]         wbits;
	logic                onehot;
	logic [3:0]          wpos;
	logic [15:0]         span;

	mrpt_msg_if #(.W(W)) push_if ();
	mrpt_msg_if #(.W(W)) pop_if ();

	mrpt_mbdec u_dec (
		.fc_i     (req_opcode_i),
		.class_i  (req_class_i),
		.index_i  (req_addr_i),
		.legal_o  (legal),
		.is_bit_o (is_bit),
		.reg_o    (dreg),
		.bit_o    (dbit)
	);

	mrpt_skid #(.W(W)) u_buf (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.in_if  (push_if),
		.out_if (pop_if)
	);

	////////////////////////////////////////////////////////////////////////
	// request classification

	assign acc      = req_valid_i & req_ready_o;
	assign mb_encap = req_from_mb_i & req_opcode_i == `MRPT_FC_ENCAP
		& req_has_param_i & req_param_i == `MRPT_PRM_QUERY;
	assign mb_reply = req_from_mb_i & req_opcode_i == `MRPT_FC_ENCAP
		& req_has_param_i & req_param_i == `MRPT_PRM_REPLY;
	assign wbits    = ~req_mask_i;
	assign onehot   = wbits != 16'h0000 && (wbits & (wbits - 16'h0001)) == 16'h0;

	always_comb begin
		wpos = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (wbits[i]) begin
				wpos = 4'(i);
			end
		end
	end

	// offset of the last bit of a range starting at dbit, counted from its first register
	assign span = {12'h000, dbit} + req_count_i - 16'h0001;

	////////////////////////////////////////////////////////////////////////
	// encapsulated error reply, sent back toward the originator

	always_comb begin
		err        = '0;
		err.kind   = mrpt_pkg::MRPT_K_ERROR;
		err.to_mb  = req_from_mb_i;
		err.opcode = `MRPT_FC_ENCAP;
		err.param  = `MRPT_PRM_REPLY;
		err.inner  = req_opcode_i;
		err.addr   = req_addr_i;
	end

	////////////////////////////////////////////////////////////////////////
	// native message toward the serial bus

	always_comb begin
		to_mb        = '0;
		to_mb.kind   = mrpt_pkg::MRPT_K_XLATE;
		to_mb.to_mb  = 1'b1;
		to_mb.inner  = req_opcode_i;
		to_mb.addr   = req_addr_i;
		to_mb.count  = req_count_i;
		to_mb.data   = req_data_i;
		to_mb.param  = {5'h00, `MRPT_CLS_HOLD};
		unique case (req_opcode_i)
			`MRPT_NAT_PRD, `MRPT_NAT_NPRD: begin
				to_mb.opcode = `MRPT_FC_RHOLD;
			end
			`MRPT_NAT_PWR: to_mb.opcode = `MRPT_FC_WREGS;
			`MRPT_NAT_NPWR: begin
				if (req_mask_i == 16'h0000) begin
					to_mb.opcode = `MRPT_FC_WREGS;
				end else if (onehot && req_count_i == 16'h0001
					&& req_addr_i != 16'h0000
					&& req_addr_i < `MRPT_COIL_LIMIT) begin
					to_mb.opcode = `MRPT_FC_WCOIL;
					to_mb.param  = {5'h00, `MRPT_CLS_COIL};
					to_mb.addr   = {req_addr_i[11:0] - 12'h001, wpos} + 16'h1;
					to_mb.data   = req_data_i[wpos] ? `MRPT_COIL_ON : 16'h0;
				end else begin
					to_mb.kind = mrpt_pkg::MRPT_K_ENCAP;
				end
			end
			default: to_mb.kind = mrpt_pkg::MRPT_K_ENCAP;
		endcase
		if (mode_i == mrpt_pkg::MRPT_MODE_MASTER
			&& to_mb.kind == mrpt_pkg::MRPT_K_XLATE) begin
			to_mb.opcode = cfg_opcode_i;
			to_mb.param  = 8'h00;
			to_mb.addr   = req_addr_i + cfg_bias_i;
			to_mb.data   = req_data_i;
		end
		if (to_mb.kind == mrpt_pkg::MRPT_K_ENCAP) begin
			to_mb.opcode = `MRPT_FC_ENCAP;
			to_mb.param  = `MRPT_PRM_QUERY;
			to_mb.addr   = req_addr_i;
			to_mb.mask   = req_mask_i;
			to_mb.data   = req_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial-bus message toward the native side

	always_comb begin
		to_nat        = '0;
		to_nat.kind   = mrpt_pkg::MRPT_K_XLATE;
		to_nat.inner  = req_opcode_i;
		to_nat.param  = {5'h00, req_class_i};
		to_nat.addr   = dreg;
		to_nat.count  = is_bit ? ({4'h0, span[15:4]} + 16'h0001) : req_count_i;
		to_nat.data   = req_data_i;
		unique case (req_opcode_i)
			`MRPT_FC_RCOIL, `MRPT_FC_RINST, `MRPT_FC_RHOLD, `MRPT_FC_RINREG:
				to_nat.opcode = `MRPT_NAT_PRD;
			`MRPT_FC_WCOIL: begin
				to_nat.opcode = `MRPT_NAT_NPWR;
				to_nat.count  = 16'h0001;
				to_nat.mask   = ~(16'h0001 << dbit);
				to_nat.data   = (req_data_i == `MRPT_COIL_ON)
					? (16'h0001 << dbit) : 16'h0000;
			end
			`MRPT_FC_WREG, `MRPT_FC_WCOILS, `MRPT_FC_WREGS:
				to_nat.opcode = `MRPT_NAT_PWR;
			default: to_nat.opcode = req_opcode_i;
		endcase
		if (!legal) begin
			to_nat.kind   = mrpt_pkg::MRPT_K_ENCAP;
			to_nat.opcode = req_opcode_i;
			to_nat.addr   = req_addr_i;
			to_nat.count  = req_count_i;
			to_nat.mask   = req_mask_i;
			to_nat.data   = req_data_i;
		end
		to_nat.data = to_nat.data & ~to_nat.mask;
	end

	////////////////////////////////////////////////////////////////////////
	// selection by port mode

	always_comb begin
		msg_d        = '0;
		msg_d.kind   = mrpt_pkg::MRPT_K_FWD;
		msg_d.to_mb  = req_from_mb_i;
		msg_d.opcode = req_opcode_i;
		msg_d.param  = req_param_i;
		msg_d.inner  = req_opcode_i;
		msg_d.addr   = req_addr_i;
		msg_d.count  = req_count_i;
		msg_d.mask   = req_mask_i;
		msg_d.data   = req_data_i;
		unique case (mode_i)
			mrpt_pkg::MRPT_NETWORK_BRIDGING_MODE: ;
			mrpt_pkg::MRPT_MODE_NATIVE: begin
				if (!req_from_mb_i && req_encap_i) begin
					msg_d = err;
				end else if (req_from_mb_i && !mb_reply) begin
					msg_d = to_nat;
				end
			end
			mrpt_pkg::MRPT_MODE_GATEWAY, mrpt_pkg::MRPT_MODE_MASTER: begin
				if (mb_encap) begin
					msg_d = err;
				end else if (mb_reply) begin
					msg_d.to_mb = 1'b0;
				end else if (!req_from_mb_i) begin
					msg_d = to_mb;
				end else if (mode_i == mrpt_pkg::MRPT_MODE_GATEWAY) begin
					msg_d = to_nat;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// one message in flight, then wait for the buffer

	assign req_ready_o   = st_q == MRPT_ST_IDLE;
	assign push_if.valid = st_q == MRPT_ST_PUSH;
	assign push_if.data  = msg_q;
	assign rsp_valid_o   = pop_if.valid;
	assign rsp_msg_o     = pop_if.data;
	assign pop_if.ready  = rsp_ready_i;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= MRPT_ST_IDLE;
		end else begin
			unique case (st_q)
				MRPT_ST_IDLE: if (req_valid_i) st_q <= MRPT_ST_PUSH;
				MRPT_ST_PUSH: if (push_if.ready) st_q <= MRPT_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			msg_q <= '0;
		end else if (acc) begin
			msg_q <= msg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_acc_gw_nat;
		acc && mode_i == mrpt_pkg::MRPT_MODE_GATEWAY && !req_from_mb_i;
	endsequence

	sequence s_acc_gw_mb;
		acc && mode_i == mrpt_pkg::MRPT_MODE_GATEWAY && req_from_mb_i
			&& req_opcode_i != `MRPT_FC_ENCAP;
	endsequence

	AST_RD_XL: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_acc_gw_nat ##0 req_opcode_i == `MRPT_NAT_NPRD |=>
		msg_q.opcode == `MRPT_FC_RHOLD && msg_q.to_mb)
		else $error("non-priority read not sent as holding read");

	AST_WR_XL: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_acc_gw_nat ##0 req_opcode_i == `MRPT_NAT_PWR |=>
		msg_q.opcode == `MRPT_FC_WREGS && msg_q.kind == mrpt_pkg::MRPT_K_XLATE)
		else $error("priority write not sent as multiple register write");

	AST_ENCAP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_acc_gw_nat ##0 req_opcode_i == `MRPT_NAT_PPRINT |=>
		msg_q.kind == mrpt_pkg::MRPT_K_ENCAP && msg_q.opcode == `MRPT_FC_ENCAP
		&& msg_q.param == `MRPT_PRM_QUERY && msg_q.inner == `MRPT_NAT_PPRINT)
		else $error("print not encapsulated");

	AST_INBIT_RO: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_acc_gw_mb ##0 req_class_i == `MRPT_CLS_INBIT
		&& req_opcode_i != `MRPT_FC_RINST |=>
		msg_q.kind == mrpt_pkg::MRPT_K_ENCAP)
		else $error("illegal input bit access translated");

	AST_COIL_MAP: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_acc_gw_mb ##0 req_class_i == `MRPT_CLS_COIL
		&& req_opcode_i == `MRPT_FC_RCOIL && req_addr_i == 16'h0011 |=>
		msg_q.opcode == `MRPT_NAT_PRD && msg_q.addr == 16'h0002)
		else $error("coil seventeen not in second register");

	AST_IDX_ZERO: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_acc_gw_mb ##0 req_addr_i == 16'h0000 |=>
		msg_q.kind != mrpt_pkg::MRPT_K_XLATE)
		else $error("reference zero translated");

	AST_NP_MASK: assert property (@(posedge clk_i) disable iff (!rstn_i)
		push_if.valid && !msg_q.to_mb && msg_q.opcode == `MRPT_NAT_NPWR
		&& msg_q.kind == mrpt_pkg::MRPT_K_XLATE |->
		(msg_q.data & msg_q.mask) == 16'h0000)
		else $error("masked bit carries data");

	AST_PW_WHOLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		push_if.valid && !msg_q.to_mb && msg_q.opcode == `MRPT_NAT_PWR
		&& msg_q.kind == mrpt_pkg::MRPT_K_XLATE |-> msg_q.mask == 16'h0000)
		else $error("priority write with mask");

	AST_BRIDGE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		acc && mode_i == mrpt_pkg::MRPT_NETWORK_BRIDGING_MODE |=>
		msg_q.kind == mrpt_pkg::MRPT_K_FWD
		&& msg_q.opcode == $past(req_opcode_i)
		&& msg_q.data == $past(req_data_i))
		else $error("bridging port altered a message");

	AST_ERR_NAT: assert property (@(posedge clk_i) disable iff (!rstn_i)
		acc && mode_i == mrpt_pkg::MRPT_MODE_NATIVE && req_encap_i
		&& !req_from_mb_i |=> msg_q.kind == mrpt_pkg::MRPT_K_ERROR
		&& msg_q.param == `MRPT_PRM_REPLY)
		else $error("native port did not reject encapsulation");

	AST_ERR_MB: assert property (@(posedge clk_i) disable iff (!rstn_i)
		acc && mb_encap && mode_i != mrpt_pkg::MRPT_NETWORK_BRIDGING_MODE
		&& mode_i != mrpt_pkg::MRPT_MODE_NATIVE |=>
		msg_q.kind == mrpt_pkg::MRPT_K_ERROR
		&& msg_q.opcode == `MRPT_FC_ENCAP && msg_q.to_mb)
		else $error("bus port did not reject encapsulation");

	AST_MASTER: assert property (@(posedge clk_i) disable iff (!rstn_i)
		acc && mode_i == mrpt_pkg::MRPT_MODE_MASTER && !req_from_mb_i
		&& req_opcode_i == `MRPT_NAT_PRD |=> msg_q.opcode == $past(cfg_opcode_i)
		&& msg_q.addr == $past(req_addr_i) + $past(cfg_bias_i))
		else $error("master bias or opcode not applied");

	AST_ONE_FLIGHT: assert property (@(posedge clk_i) disable iff (!rstn_i)
		acc |=> push_if.valid && !req_ready_o)
		else $error("accepted message not offered to buffer");
endmodule : mrpt_xlate
`default_nettype wire

// ### tb/mrpt_far_model.sv
// far-side consumer of translated messages, prompt, slow or stalled
`timescale 1ns/100ps
`default_nettype none
module mrpt_far_model (
	input  wire logic                clk_i,
	input  wire logic                rstn_i,
	input  wire logic                stall_i,
	input  wire logic                slow_i,
	input  wire logic                rsp_valid_i,
	input  wire mrpt_pkg::mrpt_msg_s rsp_msg_i,
	output logic                     rsp_ready_o
);
	mrpt_pkg::mrpt_msg_s q[$];
	logic                phase_q;
	////////////////////////////////////////////////////////////////
	// slow pacing: accept on every other cycle only
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= ~phase_q;
		end
	end
	assign rsp_ready_o = !stall_i && (!slow_i || phase_q);
	////////////////////////////////////////////////////////////////
	// collect every message accepted at an edge
	always @(posedge clk_i) begin
		if (rstn_i && rsp_valid_i && rsp_ready_o) begin
			q.push_back(rsp_msg_i);
		end
	end
endmodule : mrpt_far_model
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench of the message translator
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [1:0] KX = mrpt_pkg::MRPT_K_XLATE;
	localparam logic [1:0] KE = mrpt_pkg::MRPT_K_ENCAP;
	localparam logic [1:0] KR = mrpt_pkg::MRPT_K_ERROR;
	localparam logic [1:0] KF = mrpt_pkg::MRPT_K_FWD;
	logic                 clk_i = 1'b0;
	logic                 rstn_i = 1'b0;
	logic                 req_valid_i = 1'b0;
	logic                 req_from_mb_i = 1'b0;
	logic                 req_encap_i = 1'b0;
	logic                 req_has_param_i = 1'b0;
	logic                 stall = 1'b0;
	logic                 slow = 1'b0;
	logic                 req_ready_o;
	logic                 rsp_valid_o;
	logic                 rsp_ready_i;
	mrpt_pkg::mrpt_mode_e mode_i = mrpt_pkg::MRPT_MODE_GATEWAY;
	logic [7:0]           cfg_opcode_i = 8'h04;
	logic [7:0]           req_opcode_i = 8'h00;
	logic [7:0]           req_param_i = 8'h00;
	logic [2:0]           req_class_i = 3'h0;
	logic [15:0]          cfg_bias_i = 16'h0100;
	logic [15:0]          req_addr_i = 16'h0000;
	logic [15:0]          req_count_i = 16'h0001;
	logic [15:0]          req_mask_i = 16'h0000;
	logic [15:0]          req_data_i = 16'h0000;
	mrpt_pkg::mrpt_msg_s  rsp_msg_o;
	mrpt_pkg::mrpt_msg_s  m;
	int                   n_fail = 0;
	int                   num_checks = 0;
	always #2.5 clk_i = ~clk_i;
	mrpt_xlate mrpt_xlate_i (.clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode_i),
		.cfg_opcode_i(cfg_opcode_i), .cfg_bias_i(cfg_bias_i),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
		.req_from_mb_i(req_from_mb_i), .req_encap_i(req_encap_i),
		.req_opcode_i(req_opcode_i), .req_has_param_i(req_has_param_i),
		.req_param_i(req_param_i), .req_class_i(req_class_i),
		.req_addr_i(req_addr_i), .req_count_i(req_count_i),
		.req_mask_i(req_mask_i), .req_data_i(req_data_i),
		.rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i),
		.rsp_msg_o(rsp_msg_o));
	mrpt_far_model mrpt_far_model_i (.clk_i(clk_i), .rstn_i(rstn_i),
		.stall_i(stall), .slow_i(slow), .rsp_valid_i(rsp_valid_o),
		.rsp_msg_i(rsp_msg_o), .rsp_ready_o(rsp_ready_i));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, g);
		num_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask : chk
	task automatic send(input logic fm, en, input logic [7:0] op, prm,
			input logic [2:0] cl, input logic [15:0] ad, mk, dt);
		int n;
		n = 0;
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_from_mb_i <= fm;
		req_encap_i <= en;
		req_opcode_i <= op;
		req_has_param_i <= (prm != 8'h00);
		req_param_i <= prm;
		req_class_i <= cl;
		req_addr_i <= ad;
		req_mask_i <= mk;
		req_data_i <= dt;
		// ready only moves on a rising edge, so look at it mid-cycle
		do begin
			@(negedge clk_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 60);
		// taken at this edge, released just after it
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		if (n >= 60) chk("req_ready_o", 16'h0001, 16'h0000);
	endtask : send
	task automatic get();
		int n;
		n = 0;
		while (mrpt_far_model_i.q.size() == 0 && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		if (mrpt_far_model_i.q.size() == 0) begin
			chk("rsp_valid_o", 16'h0001, 16'h0000);
			m = '0;
		end else begin
			m = mrpt_far_model_i.q.pop_front();
		end
	endtask : get
	// one request, one response; to_mb compared unless et is 2 or above
	task automatic xa(input logic fm, en, input logic [7:0] op, prm,
			input logic [2:0] cl, input logic [15:0] ad, mk, dt,
			input logic [1:0] k, input logic [7:0] eo, input logic [1:0] et);
		send(fm, en, op, prm, cl, ad, mk, dt);
		get();
		chk("kind", {14'h0, k}, {14'h0, m.kind});
		chk("opcode", {8'h00, eo}, {8'h00, m.opcode});
		if (et < 2'd2) chk("to_mb", {14'h0, et}, {15'h0, m.to_mb});
	endtask : xa
	task automatic set_mode(input mrpt_pkg::mrpt_mode_e md);
		@(posedge clk_i);
		mode_i <= md;
	endtask : set_mode
	////////////////////////////////////////////////////////////////
	task automatic t_nat2bus();
		logic [7:0] op[6] = '{8'h20, 8'h00, 8'h1e, 8'h02, 8'h04, 8'h22};
		logic [7:0] eo[6] = '{8'h03, 8'h03, 8'h10, 8'h10, 8'h11, 8'h11};
		for (int i = 0; i < 6; i++) begin
			xa(0, 0, op[i], 0, 0, 16'h0005, 0, 0, i < 4 ? KX : KE,
				eo[i], 1);
			if (i >= 4) chk("param", 16'h0001, {8'h00, m.param});
		end
		xa(0, 0, 8'h02, 0, 0, 16'h0003, 16'hffef, 16'h0010, KX, 8'h05, 1);
		chk("addr", 16'h0025, m.addr);
		chk("data", 16'hff00, m.data);
		$display("test native to bus done");
	endtask : t_nat2bus
	task automatic t_bus2nat();
		logic [7:0] fc[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
			8'h0f, 8'h10};
		logic [2:0] cl[8] = '{3'h0, 3'h1, 3'h4, 3'h3, 3'h0, 3'h4, 3'h0, 3'h4};
		logic [7:0] eo[8] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h02, 8'h1e,
			8'h1e, 8'h1e};
		for (int i = 0; i < 8; i++) begin
			xa(1, 0, fc[i], 0, cl[i], 16'h0025, 0, 16'h1234, KX,
				eo[i], 0);
			if (cl[i] < 3'h2) chk("addr", 16'h0003, m.addr);
			if (i == 4) chk("mask", 16'hffef, m.mask);
			if (i > 4) chk("mask", 16'h0000, m.mask);
		end
		xa(1, 0, 8'h05, 0, 3'h1, 16'h0005, 0, 0, KE, 8'h05, 0);
		xa(1, 0, 8'h06, 0, 3'h3, 16'h0005, 0, 0, KE, 8'h06, 0);
		xa(1, 0, 8'h02, 0, 3'h0, 16'h0005, 0, 0, KE, 8'h02, 0);
		xa(1, 0, 8'h04, 0, 3'h4, 16'h0005, 0, 0, KE, 8'h04, 0);
		xa(1, 0, 8'h03, 0, 3'h4, 16'h0000, 0, 0, KE, 8'h03, 0);
		xa(1, 0, 8'h03, 0, 3'h4, 16'h0001, 0, 0, KX, 8'h20, 0);
		xa(1, 0, 8'h01, 0, 3'h0, 16'h0011, 0, 0, KX, 8'h20, 0);
		chk("addr", 16'h0002, m.addr);
		$display("test bus to native done");
	endtask : t_bus2nat
	task automatic t_err();
		set_mode(mrpt_pkg::MRPT_MODE_NATIVE);
		xa(0, 1, 8'h03, 0, 3'h4, 16'h0005, 0, 0, KR, 8'h11, 0);
		chk("param", 16'h0002, {8'h00, m.param});
		xa(1, 0, 8'h03, 0, 3'h4, 16'h0005, 0, 0, KX, 8'h20, 0);
		chk("addr", 16'h0005, m.addr);
		set_mode(mrpt_pkg::MRPT_MODE_GATEWAY);
		xa(1, 0, 8'h11, 8'h01, 0, 16'h0005, 0, 0, KR, 8'h11, 1);
		chk("param", 16'h0002, {8'h00, m.param});
		xa(1, 0, 8'h11, 8'h02, 0, 16'h0005, 0, 0, KF, 8'h11, 0);
		chk("param", 16'h0002, {8'h00, m.param});
		$display("test error replies done");
	endtask : t_err
	task automatic t_master();
		set_mode(mrpt_pkg::MRPT_MODE_MASTER);
		// native controller issues the priority read only
		xa(0, 0, 8'h20, 0, 0, 16'h0005, 0, 0, KX, 8'h04, 1);
		chk("addr", 16'h0105, m.addr);
		chk("param", 16'h0000, {8'h00, m.param});
		xa(1, 0, 8'h03, 0, 3'h4, 16'h0005, 0, 0, KF, 8'h03, 2);
		$display("test master done");
	endtask : t_master
	task automatic t_bridge();
		set_mode(mrpt_pkg::MRPT_NETWORK_BRIDGING_MODE);
		xa(0, 0, 8'h04, 0, 0, 16'h0007, 0, 0, KF, 8'h04, 2);
		@(posedge clk_i);
		stall <= 1'b1;
		for (int i = 1; i < 4; i++) begin
			send(1, 0, 8'h03, 0, 3'h4, i[15:0], 0, 0);
		end
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_addr_i <= 16'h0004;
		repeat (4) begin
			@(posedge clk_i);
			chk("req_ready_o", 16'h0000, {15'h0, req_ready_o});
		end
		chk("rsp_valid_o", 16'h0001, {15'h0, rsp_valid_o});
		stall <= 1'b0;
		slow <= 1'b1;
		send(1, 0, 8'h03, 0, 3'h4, 16'h0004, 0, 0);
		for (int i = 1; i < 5; i++) begin
			get();
			chk("addr", i[15:0], m.addr);
		end
		slow <= 1'b0;
		$display("test bridging and stall done");
	endtask : t_bridge
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#(20000 * 5);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_nat2bus();
		t_bus2nat();
		t_err();
		t_master();
		t_bridge();
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
